// [src/rcv_pkg.sv]
// Shared constants and carriers for the remote command validator.
// Assumes a parser in front that has already split commands into checks.
package rcv_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_ERRQ    = 8'h00; // Read pops oldest error
  localparam logic [7:0] ADDR_ESR     = 8'h04;
  localparam logic [7:0] ADDR_ESE     = 8'h08;
  localparam logic [7:0] ADDR_COND_EN = 8'h0c;
  localparam logic [7:0] ADDR_CMD     = 8'h10; // Write-only pulses
  localparam logic [7:0] ADDR_MODE    = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_FAULT   = 8'h1c; // Read clears
  localparam logic [7:0] ADDR_RATED_I = 8'h20;
  localparam logic [7:0] ADDR_RATED_P = 8'h24;
  localparam logic [7:0] ADDR_ISET    = 8'h28;
  localparam logic [7:0] ADDR_PSET    = 8'h2c;

  // Field positions
  localparam int CMD_CLS_BIT      = 0;
  localparam int CMD_DEV_RST_BIT  = 1; // legacy_device_reset_cmd
  localparam int CMD_PROT_CLR_BIT = 2;
  localparam int MODE_SRC_OK_BIT  = 0;
  localparam int MODE_REMOTE_BIT  = 1;
  localparam int MODE_SHARE_BIT   = 2;
  localparam int MODE_CAL_BIT     = 3;
  localparam int MODE_TRIP_OFF_BIT = 4;
  localparam int ESR_EXEC_BIT     = 4;
  localparam int ESR_CMD_BIT      = 5;

  // Queue geometry
  localparam int ERRQ_DEPTH = 4;
  localparam int ERRQ_AW    = 2;

  // Reset values
  localparam logic [15:0] RATED_I_RST = 16'h0064; // Plain default
  localparam logic [15:0] RATED_P_RST = 16'h03e8; // Plain default
  localparam logic [4:0]  MODE_RST    = 5'h03;

  // Error codes, 16-bit two's complement
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_GET      = 16'hff97; // -105
  localparam logic [15:0] ERR_SUFFIX   = 16'hff8e; // -114
  localparam logic [15:0] ERR_EXPONENT = 16'hff85; // -123
  localparam logic [15:0] ERR_STRING   = 16'hff69; // -151
  localparam logic [15:0] ERR_PARAM    = 16'hff24; // -220
  localparam logic [15:0] ERR_CONFLICT = 16'hff23; // -221
  localparam logic [15:0] ERR_RANGE    = 16'hff22; // -222
  localparam logic [15:0] ERR_OVERFLOW = 16'hfea2; // -350
  localparam logic [15:0] CMD_CLASS_LO = 16'hff39; // -199
  localparam logic [15:0] CMD_CLASS_HI = 16'hff9c; // -100
  localparam logic [15:0] EXE_CLASS_LO = 16'hfed5; // -299
  localparam logic [15:0] EXE_CLASS_HI = 16'hff38; // -200

  // Argument limits
  localparam logic [15:0] EXP_MAX_POS  = 16'h7d00; // 32000
  localparam logic [15:0] EXP_MAX_NEG  = 16'h8300; // -32000
  localparam logic [31:0] CHAN_MIN     = 32'h0000_0002;
  localparam logic [31:0] CHAN_MAX     = 32'h0000_0032; // 50
  localparam logic [31:0] SEQ_MAX      = 32'h0000_000a; // 10
  localparam logic [31:0] STEP_MAX     = 32'h0000_0063; // 99
  localparam logic [31:0] GPIB_MAX     = 32'h0000_001e; // 30
  localparam logic [31:0] COUNT_MAX    = 32'h0000_270f; // 9999
  localparam logic [31:0] ESE_MAX      = 32'h0000_00ff;
  localparam logic [31:0] COND_EN_MAX  = 32'h0000_ffff;
  localparam logic [31:0] ONE_MIN      = 32'h0000_0001;
  localparam logic [7:0]  CURR_PCT     = 8'h67; // 103
  localparam logic [7:0]  POWER_PCT    = 8'h65; // 101
  localparam logic [7:0]  PCT_FULL     = 8'h64; // 100

  typedef enum logic [3:0] {
    RCV_KIND_GET     = 4'h0,
    RCV_KIND_CHAN    = 4'h1,
    RCV_KIND_SEQ     = 4'h2,
    RCV_KIND_STEP    = 4'h3,
    RCV_KIND_GPIB    = 4'h4,
    RCV_KIND_COUNT   = 4'h5,
    RCV_KIND_CURR    = 4'h6,
    RCV_KIND_POWER   = 4'h7,
    RCV_KIND_BOOL    = 4'h8,
    RCV_KIND_ESE     = 4'h9,
    RCV_KIND_COND_EN = 4'ha,
    RCV_KIND_STRING  = 4'hb
  } rcv_kind_t;

  typedef struct packed {
    logic        valid;
    rcv_kind_t   kind;
    logic        legacy;   // Short-form legacy command
    logic        query;
    logic        str_bad;  // Bad string length or character
    logic        mid_msg;  // Trigger arrived inside a message
    logic [15:0] exponent; // Signed decimal exponent
    logic [31:0] value;
  } rcv_req_t;

  typedef struct packed {
    logic        done;
    logic        accept;
    logic        echo;     // Echo query header in reply
    logic [15:0] code;
  } rcv_res_t;

endpackage : rcv_pkg

// [src/rcv_validate.sv]
// Parameter validation, error queue and event status for the remote port.
// Assumes one check request per cycle from a parser and a plain register port.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/10ps
module rcv_validate
  import rcv_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        ce_in,
  // Register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out,
  // Check requests
  input  wire rcv_req_t    req_in,
  output rcv_res_t         result_out,
  // Live instrument events
  input  wire logic [15:0] cond_in,
  input  wire logic [7:0]  trip_in,
  input  wire logic [7:0]  fault_in,
  // Status and setpoints
  output logic             esb_out,
  output logic             cond_sum_out,
  output logic [31:0]      iset_out,
  output logic [31:0]      pset_out,
  output logic             out_on_out,
  output logic [7:0]       tripped_out
);

  typedef struct packed {
    logic [ERRQ_DEPTH-1:0][15:0] q;
    logic [ERRQ_AW-1:0]          rd_ptr;
    logic [ERRQ_AW-1:0]          wr_ptr;
    logic [ERRQ_AW:0]            cnt;
    logic [7:0]                  esr;
    logic [7:0]                  ese;
    logic [15:0]                 cond_en;
    logic [4:0]                  mode;
    logic [15:0]                 rated_i;
    logic [15:0]                 rated_p;
    logic [31:0]                 iset;
    logic [31:0]                 pset;
    logic                        out_on;
    logic [7:0]                  tripped;
    logic [7:0]                  faults;
    logic [31:0]                 rdata;
    rcv_res_t                    res;
    logic                        esb;
    logic                        cond_sum;
  } rcv_state_t;

  localparam logic [ERRQ_AW:0] ERRQ_FULL = (ERRQ_AW+1)'(ERRQ_DEPTH);

  rcv_state_t r;
  rcv_state_t next_r;

  // Signed window test on 16-bit codes
  function automatic logic in_class(input logic [15:0] c, input logic [15:0] lo, input logic [15:0] hi);
    in_class = ($signed(c) >= $signed(lo)) && ($signed(c) <= $signed(hi));
  endfunction : in_class

  function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // Next-state logic for the whole block
  always_comb begin
    logic [15:0] code;
    logic        accept;
    logic        push;
    logic        mode_bad;
    logic [39:0] lhs;
    logic [39:0] rhs;
    logic        rd_hit;
    logic        wr_hit;
    code     = ERR_NONE;
    accept   = 1'b0;
    push     = 1'b0;
    mode_bad = 1'b0;
    lhs      = 40'h00_0000_0000;
    rhs      = 40'h00_0000_0000;
    rd_hit   = rd_in;
    wr_hit   = wr_in;
    next_r   = r;
    next_r.res.done = 1'b0;

    // Register reads; the data stand only in the following cycle
    next_r.rdata = 32'h0000_0000;
    if (rd_hit) begin
      case (addr_in)
        ADDR_ERRQ: begin
          if (r.cnt != '0) begin
            next_r.rdata  = {{16{r.q[r.rd_ptr][15]}}, r.q[r.rd_ptr]};
            next_r.rd_ptr = r.rd_ptr + ERRQ_AW'(1);
            next_r.cnt    = r.cnt - (ERRQ_AW+1)'(1);
          end else begin
            next_r.rdata = {16'h0000, ERR_NONE};
          end
        end
        ADDR_ESR:     next_r.rdata = {24'h00_0000, r.esr};
        ADDR_ESE:     next_r.rdata = {24'h00_0000, r.ese};
        ADDR_COND_EN: next_r.rdata = {16'h0000, r.cond_en};
        ADDR_MODE:    next_r.rdata = {27'h000_0000, r.mode};
        ADDR_STATUS:  next_r.rdata = {20'h0_0000, r.tripped, r.out_on, r.cnt};
        ADDR_FAULT: begin
          next_r.rdata  = {24'h00_0000, r.faults};
          next_r.faults = 8'h00;
        end
        ADDR_RATED_I: next_r.rdata = {16'h0000, r.rated_i};
        ADDR_RATED_P: next_r.rdata = {16'h0000, r.rated_p};
        ADDR_ISET:    next_r.rdata = r.iset;
        ADDR_PSET:    next_r.rdata = r.pset;
        default:      next_r.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes and command pulses
    if (wr_hit) begin
      case (addr_in)
        ADDR_ESE:     next_r.ese     = wdata_in[7:0];
        ADDR_COND_EN: next_r.cond_en = wdata_in[15:0];
        ADDR_MODE:    next_r.mode    = wdata_in[4:0];
        ADDR_RATED_I: next_r.rated_i = wdata_in[15:0];
        ADDR_RATED_P: next_r.rated_p = wdata_in[15:0];
        ADDR_CMD: begin
          if (wdata_in[CMD_CLS_BIT]) begin
            next_r.cnt    = '0;
            next_r.rd_ptr = '0;
            next_r.wr_ptr = '0;
            next_r.esr    = 8'h00;
          end
          // Device reset restores setpoints but never the fault bits
          if (wdata_in[CMD_DEV_RST_BIT]) begin
            next_r.iset   = 32'h0000_0000;
            next_r.pset   = 32'h0000_0000;
            next_r.out_on = 1'b0;
          end
          // Protection clear only releases trips
          if (wdata_in[CMD_PROT_CLR_BIT]) begin
            next_r.tripped = 8'h00;
          end
        end
        default: ;
      endcase
    end

    // Incoming events win over any clear in the same cycle
    next_r.faults  = next_r.faults | fault_in;
    next_r.tripped = next_r.tripped | trip_in;
    if ((trip_in != 8'h00) && r.mode[MODE_TRIP_OFF_BIT]) begin
      next_r.out_on = 1'b0;
    end

    // Argument validation, first failing check decides the code
    mode_bad = !r.mode[MODE_SRC_OK_BIT] || !r.mode[MODE_REMOTE_BIT] ||
               r.mode[MODE_SHARE_BIT] || r.mode[MODE_CAL_BIT];
    if (req_in.valid) begin
      accept = 1'b1;
      if (req_in.kind == RCV_KIND_GET) begin
        if (req_in.mid_msg) begin
          code = ERR_GET;
        end
      end else if ($signed(req_in.exponent) > $signed(EXP_MAX_POS) ||
                   $signed(req_in.exponent) < $signed(EXP_MAX_NEG)) begin
        code = ERR_EXPONENT;
      end else if (req_in.str_bad) begin
        code = ERR_STRING;
      end else if (req_in.legacy && !req_in.query && mode_bad) begin
        code = ERR_CONFLICT;
      end else begin
        case (req_in.kind)
          RCV_KIND_CHAN:    if (!in_range(req_in.value, CHAN_MIN, CHAN_MAX)) code = ERR_SUFFIX;
          RCV_KIND_SEQ:     if (!in_range(req_in.value, ONE_MIN, SEQ_MAX)) code = ERR_SUFFIX;
          RCV_KIND_STEP:    if (!in_range(req_in.value, ONE_MIN, STEP_MAX)) code = ERR_SUFFIX;
          RCV_KIND_GPIB:    if (!in_range(req_in.value, ONE_MIN, GPIB_MAX)) code = ERR_RANGE;
          RCV_KIND_COUNT:   if (!in_range(req_in.value, ONE_MIN, COUNT_MAX)) code = ERR_RANGE;
          RCV_KIND_ESE:     if (req_in.value > ESE_MAX) code = ERR_RANGE;
          RCV_KIND_COND_EN: if (req_in.value > COND_EN_MAX) code = ERR_RANGE;
          RCV_KIND_BOOL:    if (req_in.value > ONE_MIN) code = ERR_PARAM;
          RCV_KIND_CURR: begin
            lhs = req_in.value * PCT_FULL;
            rhs = {24'h00_0000, r.rated_i} * CURR_PCT;
            if (lhs > rhs) code = ERR_RANGE;
          end
          RCV_KIND_POWER: begin
            lhs = req_in.value * PCT_FULL;
            rhs = {24'h00_0000, r.rated_p} * POWER_PCT;
            if (lhs > rhs) code = ERR_RANGE;
          end
          default: ;
        endcase
      end
      accept = (code == ERR_NONE);
      push   = !accept;
    end

    // Accepted values take effect
    if (accept && !req_in.query) begin
      case (req_in.kind)
        RCV_KIND_CURR:    next_r.iset    = req_in.value;
        RCV_KIND_POWER:   next_r.pset    = req_in.value;
        RCV_KIND_BOOL:    next_r.out_on  = req_in.value[0];
        RCV_KIND_ESE:     next_r.ese     = req_in.value[7:0];
        RCV_KIND_COND_EN: next_r.cond_en = req_in.value[15:0];
        default: ;
      endcase
    end

    // Queue push after any pop or clear, so a fresh error survives
    if (push) begin
      if (next_r.cnt == ERRQ_FULL) begin
        next_r.q[next_r.wr_ptr - ERRQ_AW'(1)] = ERR_OVERFLOW;
      end else begin
        next_r.q[next_r.wr_ptr] = code;
        next_r.wr_ptr = next_r.wr_ptr + ERRQ_AW'(1);
        next_r.cnt    = next_r.cnt + (ERRQ_AW+1)'(1);
      end
      if (in_class(code, CMD_CLASS_LO, CMD_CLASS_HI)) next_r.esr[ESR_CMD_BIT] = 1'b1;
      if (in_class(code, EXE_CLASS_LO, EXE_CLASS_HI)) next_r.esr[ESR_EXEC_BIT] = 1'b1;
    end

    next_r.res.done   = req_in.valid;
    next_r.res.accept = accept;
    next_r.res.echo   = req_in.valid && req_in.legacy && req_in.query;
    next_r.res.code   = code;

    // Summaries lag the masks by one cycle to keep outputs registered
    next_r.esb      = |(r.esr & r.ese);
    next_r.cond_sum = |(cond_in & r.cond_en);
  end

  // One register for all state, frozen while the enable is low
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r         <= '0;
      r.mode    <= MODE_RST;
      r.rated_i <= RATED_I_RST;
      r.rated_p <= RATED_P_RST;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign rdata_out    = r.rdata;
  assign result_out   = r.res;
  assign esb_out      = r.esb;
  assign cond_sum_out = r.cond_sum;
  assign iset_out     = r.iset;
  assign pset_out     = r.pset;
  assign out_on_out   = r.out_on;
  assign tripped_out  = r.tripped;

  // Checks on observable behaviour
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  logic plain_req;
  assign plain_req = ce_in && req_in.valid && !req_in.str_bad && !req_in.legacy &&
                     $signed(req_in.exponent) <= $signed(EXP_MAX_POS) &&
                     $signed(req_in.exponent) >= $signed(EXP_MAX_NEG);

  empty_read_a: assert property (ce_in && rd_in && addr_in == ADDR_ERRQ && r.cnt == '0
    |=> rdata_out == 32'h0000_0000) else $error("empty queue read not zero");
  overflow_slot_a: assert property (ce_in && r.cnt == ERRQ_FULL && r.res.done == 1'b0 && !rd_in && !wr_in
    && req_in.valid && req_in.kind == RCV_KIND_GET && req_in.mid_msg
    |=> r.cnt == ERRQ_FULL && r.q[r.wr_ptr - ERRQ_AW'(1)] == ERR_OVERFLOW) else $error("overflow not marked");
  chan_suffix_a: assert property (plain_req && req_in.kind == RCV_KIND_CHAN
    && (req_in.value < CHAN_MIN || req_in.value > CHAN_MAX)
    |=> result_out.done && result_out.code == ERR_SUFFIX) else $error("channel range not refused");
  exp_limit_a: assert property (ce_in && req_in.valid && req_in.kind != RCV_KIND_GET
    && $signed(req_in.exponent) > $signed(EXP_MAX_POS) |=> result_out.code == ERR_EXPONENT)
    else $error("large exponent not refused");
  cmd_flag_a: assert property (ce_in && req_in.valid && req_in.kind == RCV_KIND_GET && req_in.mid_msg
    && !(wr_in && addr_in == ADDR_CMD) |=> r.esr[ESR_CMD_BIT] ##1 esb_out == r.ese[ESR_CMD_BIT] || r.esb)
    else $error("command error flag missing");
  legacy_state_a: assert property (ce_in && req_in.valid && req_in.legacy && !req_in.query
    && req_in.kind == RCV_KIND_CURR && !req_in.str_bad && r.mode[MODE_CAL_BIT]
    && $signed(req_in.exponent) <= $signed(EXP_MAX_POS) && $signed(req_in.exponent) >= $signed(EXP_MAX_NEG)
    |=> result_out.code == ERR_CONFLICT && $stable(iset_out)) else $error("legacy change not refused");
  prot_keep_a: assert property (ce_in && wr_in && addr_in == ADDR_CMD && wdata_in[CMD_PROT_CLR_BIT]
    && !wdata_in[CMD_DEV_RST_BIT] && !req_in.valid && trip_in == 8'h00
    |=> tripped_out == 8'h00 && $stable(iset_out) && $stable(pset_out)) else $error("protection clear wrong");
  fault_keep_a: assert property (ce_in && wr_in && addr_in == ADDR_CMD && wdata_in[CMD_DEV_RST_BIT]
    |=> r.faults == ($past(r.faults) | $past(fault_in))) else $error("reset touched fault bits");
  curr_limit_a: assert property (plain_req && req_in.kind == RCV_KIND_CURR && !req_in.query
    && req_in.value * PCT_FULL > {24'h00_0000, r.rated_i} * CURR_PCT
    |=> result_out.code == ERR_RANGE && $stable(iset_out)) else $error("current limit not kept");
  cond_sum_a: assert property (ce_in ##1 ce_in
    |-> cond_sum_out == |($past(cond_in) & $past(r.cond_en))) else $error("condition summary wrong");

  queue_fill_c: cover property (r.cnt == ERRQ_FULL);
  overflow_c:   cover property (ce_in && r.cnt == ERRQ_FULL && req_in.valid ##1 result_out.code != ERR_NONE);
  drain_c:      cover property (ce_in && rd_in && addr_in == ADDR_ERRQ && r.cnt == (ERRQ_AW+1)'(1));
  echo_c:       cover property (result_out.echo);

endmodule : rcv_validate

// [tb/rcv_host.sv]
// Remote controller model: issues one check request and collects the answer.
// Assumes the validator takes a request at an edge and answers one cycle later.
`timescale 1ns/10ps
module rcv_host
  import rcv_pkg::*;
(
  // Clock
  input  wire logic     mclk_in,
  // Check port
  output rcv_req_t      req_out,
  input  wire rcv_res_t res_in
);
  initial req_out = '0;

  // Request stands one edge; idle fields then flip so stale data never looks valid
  task automatic send(input rcv_req_t r, output rcv_res_t res);
    @(posedge mclk_in);
    req_out <= r;
    @(posedge mclk_in);
    req_out <= {1'b0, ~r[$bits(rcv_req_t)-2:0]};
    #1 res = res_in;
  endtask : send
endmodule : rcv_host

// [tb/remote_cmd_validate_errq_test.sv]
// Self-checking bench for the validator: random checks plus corner cases.
// Assumes register port and check port timing as handed over; ce_in held high except for one request sent while it is low.
`timescale 1ns/10ps
module remote_cmd_validate_errq_test
  import rcv_pkg::*;
();
  logic        mclk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        ce_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out, iset_out, pset_out;
  rcv_req_t    req_in;
  rcv_res_t    result_out;
  logic [15:0] cond_in = 16'h0;
  logic [7:0]  trip_in = 8'h0;
  logic [7:0]  fault_in = 8'h0;
  logic [7:0]  tripped_out;
  logic        esb_out, cond_sum_out, out_on_out;
  int          err_count = 0;
  int          num_checks = 0;
  int          seed = 49934;
  // Reference model state
  logic [15:0] mq[$];
  logic [31:0] m_esr = 32'h0, m_iset = 32'h0, m_pset = 32'h0;
  logic [15:0] m_cen = 16'h0, m_ri = RATED_I_RST, m_rp = RATED_P_RST;
  logic [7:0]  m_ese = 8'h0, m_trip = 8'h0;
  logic [4:0]  m_mode = MODE_RST;
  logic        m_out = 1'b0;
  rcv_kind_t   ovf_k[5] = '{RCV_KIND_CHAN, RCV_KIND_GPIB, RCV_KIND_BOOL, RCV_KIND_SEQ, RCV_KIND_STEP};
  logic [31:0] ovf_v[5] = '{32'h33, 32'h0, 32'h2, 32'hb, 32'h64};

  always #25 mclk_in = ~mclk_in;

  rcv_host host_u (.mclk_in(mclk_in), .req_out(req_in), .res_in(result_out));

  rcv_validate dut_u (
    .mclk_in(mclk_in), .reset_n_in(reset_n_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .req_in(req_in), .result_out(result_out),
    .cond_in(cond_in), .trip_in(trip_in), .fault_in(fault_in), .esb_out(esb_out),
    .cond_sum_out(cond_sum_out), .iset_out(iset_out), .pset_out(pset_out), .out_on_out(out_on_out),
    .tripped_out(tripped_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // Model queue: full queue turns its newest entry into overflow
  function automatic void push(logic [15:0] c);
    if ($signed(c) >= $signed(CMD_CLASS_LO) && $signed(c) <= $signed(CMD_CLASS_HI)) m_esr[ESR_CMD_BIT] = 1'b1;
    if ($signed(c) >= $signed(EXE_CLASS_LO) && $signed(c) <= $signed(EXE_CLASS_HI)) m_esr[ESR_EXEC_BIT] = 1'b1;
    if (mq.size() == ERRQ_DEPTH) mq[ERRQ_DEPTH-1] = ERR_OVERFLOW;
    else mq.push_back(c);
  endfunction : push

  // Expected code in the handed-over priority order
  function automatic logic [15:0] exp_code(rcv_req_t r);
    logic [63:0] v100;
    v100 = 64'(r.value) * 64'(PCT_FULL);
    if (r.kind == RCV_KIND_GET) return r.mid_msg ? ERR_GET : ERR_NONE;
    if ($signed(r.exponent) > $signed(EXP_MAX_POS) || $signed(r.exponent) < $signed(EXP_MAX_NEG)) return ERR_EXPONENT;
    if (r.str_bad) return ERR_STRING;
    if (r.legacy && !r.query && (!m_mode[MODE_SRC_OK_BIT] || !m_mode[MODE_REMOTE_BIT] || m_mode[MODE_SHARE_BIT] ||
        m_mode[MODE_CAL_BIT])) return ERR_CONFLICT;
    case (r.kind)
      RCV_KIND_CHAN:    if (r.value < CHAN_MIN || r.value > CHAN_MAX) return ERR_SUFFIX;
      RCV_KIND_SEQ:     if (r.value < ONE_MIN || r.value > SEQ_MAX) return ERR_SUFFIX;
      RCV_KIND_STEP:    if (r.value < ONE_MIN || r.value > STEP_MAX) return ERR_SUFFIX;
      RCV_KIND_GPIB:    if (r.value < ONE_MIN || r.value > GPIB_MAX) return ERR_RANGE;
      RCV_KIND_COUNT:   if (r.value < ONE_MIN || r.value > COUNT_MAX) return ERR_RANGE;
      RCV_KIND_ESE:     if (r.value > ESE_MAX) return ERR_RANGE;
      RCV_KIND_COND_EN: if (r.value > COND_EN_MAX) return ERR_RANGE;
      RCV_KIND_CURR:    if (v100 > 64'(m_ri) * 64'(CURR_PCT)) return ERR_RANGE;
      RCV_KIND_POWER:   if (v100 > 64'(m_rp) * 64'(POWER_PCT)) return ERR_RANGE;
      RCV_KIND_BOOL:    if (r.value > ONE_MIN) return ERR_PARAM;
      default: ;
    endcase
    return ERR_NONE;
  endfunction : exp_code

  function automatic rcv_req_t mk(rcv_kind_t k, logic [31:0] v, logic [3:0] f);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.value = v;
    {mk.legacy, mk.query, mk.str_bad, mk.mid_msg} = f;
  endfunction : mk

  // Random request biased to the edges of each legal range
  function automatic rcv_req_t rnd_req();
    logic [31:0] x, lo, hi, v;
    rcv_kind_t   k;
    x = $random(seed);
    k = rcv_kind_t'(x[3:0] % 4'hc);
    lo = (k == RCV_KIND_CHAN) ? CHAN_MIN :
         (k inside {RCV_KIND_SEQ, RCV_KIND_STEP, RCV_KIND_GPIB, RCV_KIND_COUNT}) ? ONE_MIN : 32'h0;
    case (k)
      RCV_KIND_CHAN:  hi = CHAN_MAX;
      RCV_KIND_SEQ:   hi = SEQ_MAX;
      RCV_KIND_STEP:  hi = STEP_MAX;
      RCV_KIND_GPIB:  hi = GPIB_MAX;
      RCV_KIND_COUNT: hi = COUNT_MAX;
      RCV_KIND_ESE:   hi = ESE_MAX;
      RCV_KIND_CURR:  hi = 32'((64'(m_ri) * 64'(CURR_PCT)) / 64'(PCT_FULL));
      RCV_KIND_POWER: hi = 32'((64'(m_rp) * 64'(POWER_PCT)) / 64'(PCT_FULL));
      RCV_KIND_BOOL:  hi = ONE_MIN;
      default:        hi = COND_EN_MAX;
    endcase
    case (x[19:17])
      3'h0: v = lo - 32'h1;
      3'h1: v = lo;
      3'h2: v = hi;
      3'h3: v = hi + 32'h1;
      default: v = lo + 32'($unsigned($random(seed))) % (hi - lo + 32'h1);
    endcase
    rnd_req = mk(k, v, {x[5:4] == 2'h0, x[7:6] == 2'h0, x[10:8] == 3'h0, x[11]});
    rnd_req.exponent = (x[14:12] != 3'h0) ? 16'h0 : x[15] ? EXP_MAX_POS + {15'h0, x[16]} : EXP_MAX_NEG - {15'h0, x[16]};
  endfunction : rnd_req

  // Register write; model follows every side effect
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    wdata_in <= ~d;
    case (a)
      ADDR_ESE:     m_ese = d[7:0];
      ADDR_COND_EN: m_cen = d[15:0];
      ADDR_MODE:    m_mode = d[4:0];
      ADDR_RATED_I: m_ri = d[15:0];
      ADDR_RATED_P: m_rp = d[15:0];
      ADDR_CMD: begin
        if (d[CMD_CLS_BIT]) mq.delete();
        if (d[CMD_CLS_BIT]) m_esr = 32'h0;
        if (d[CMD_DEV_RST_BIT]) {m_iset, m_pset, m_out} = '0;
        if (d[CMD_PROT_CLR_BIT]) m_trip = 8'h0;
      end
      default: ;
    endcase
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : reg_rd

  task automatic pop_chk();
    logic [31:0] d, e;
    reg_rd(ADDR_ERRQ, d);
    e = (mq.size() != 0) ? {{16{mq[0][15]}}, mq[0]} : 32'h0;
    if (mq.size() != 0) void'(mq.pop_front());
    chk(d, e, "error queue read");
  endtask : pop_chk

  task automatic stat_chk();
    logic [31:0] d;
    reg_rd(ADDR_STATUS, d);
    chk(d, {20'h0, m_trip, m_out, 3'(mq.size())}, "status");
    reg_rd(ADDR_ESR, d);
    chk(d, m_esr, "event status");
    chk({31'h0, esb_out}, {31'h0, |(m_esr[7:0] & m_ese)}, "esb");
    chk({31'h0, cond_sum_out}, {31'h0, |(cond_in & m_cen)}, "cond summary");
    chk(iset_out, m_iset, "iset");
    chk({pset_out[30:0], out_on_out}, {m_pset[30:0], m_out}, "pset out_on");
  endtask : stat_chk

  task automatic check_req(input rcv_req_t r);
    rcv_res_t    res;
    logic [15:0] e;
    e = exp_code(r);
    host_u.send(r, res);
    chk({15'h0, res.done, res.code}, {15'h1, e}, "code");
    chk({30'h0, res.accept, res.echo}, {30'h0, e == ERR_NONE, r.legacy && r.query}, "accept echo");
    if (e != ERR_NONE) push(e);
    else if (!r.query) begin
      case (r.kind)
        RCV_KIND_CURR:    m_iset = r.value;
        RCV_KIND_POWER:   m_pset = r.value;
        RCV_KIND_BOOL:    m_out = r.value[0];
        RCV_KIND_ESE:     m_ese = r.value[7:0];
        RCV_KIND_COND_EN: m_cen = r.value[15:0];
        default: ;
      endcase
    end
  endtask : check_req

  // Hang guard, far beyond the roughly 1300 cycles the run needs
  initial begin
    repeat (40000) @(posedge mclk_in);
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  initial begin
    logic [31:0] d;
    rcv_res_t    res0;
    repeat (6) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    reg_rd(ADDR_MODE, d);
    chk(d, {27'h0, MODE_RST}, "mode reset");
    reg_rd(ADDR_RATED_P, d);
    chk(d, {16'h0, RATED_P_RST}, "rated power reset");
    reg_wr(ADDR_RATED_I, 32'h0000_00c8);
    reg_rd(ADDR_RATED_I, d);
    chk(d, 32'h0000_00c8, "rated current");
    reg_rd(8'h3c, d);
    chk(d, 32'h0, "unmapped read");
    pop_chk();
    stat_chk();
    $display("test reset done");
    // Six failures into a four-deep queue, then drain past empty
    for (int i = 0; i < 5; i++) check_req(mk(ovf_k[i], ovf_v[i], 4'h0));
    check_req(mk(RCV_KIND_GET, 32'h0, 4'h1));
    stat_chk();
    repeat (5) pop_chk();
    check_req(mk(RCV_KIND_GET, 32'h0, 4'h1));
    check_req(mk(RCV_KIND_GET, 32'h0, 4'h0));
    reg_wr(ADDR_CMD, 32'h1 << CMD_CLS_BIT);
    stat_chk();
    pop_chk();
    $display("test queue done");
    // Legacy state conflict and query echo
    reg_wr(ADDR_MODE, 32'h07);
    check_req(mk(RCV_KIND_CURR, 32'h1, 4'h8));
    check_req(mk(RCV_KIND_CURR, 32'h1, 4'hc));
    reg_wr(ADDR_MODE, {27'h0, MODE_RST});
    check_req(mk(RCV_KIND_CURR, 32'h32, 4'h8));
    // Trips and faults with trip-off mode, then protection clear and device reset
    reg_wr(ADDR_MODE, 32'h13);
    check_req(mk(RCV_KIND_BOOL, 32'h1, 4'h0));
    @(posedge mclk_in) trip_in <= 8'h05;
    fault_in <= 8'h30;
    @(posedge mclk_in) trip_in <= 8'h00;
    fault_in <= 8'h00;
    m_trip = 8'h05;
    m_out = 1'b0;
    stat_chk();
    reg_wr(ADDR_CMD, 32'h1 << CMD_PROT_CLR_BIT);
    stat_chk();
    reg_wr(ADDR_CMD, 32'h1 << CMD_DEV_RST_BIT);
    reg_rd(ADDR_FAULT, d);
    chk(d, 32'h30, "faults kept");
    reg_rd(ADDR_FAULT, d);
    chk(d, 32'h0, "faults cleared on read");
    stat_chk();
    // Request while the enable is low must leave no trace
    @(posedge mclk_in) ce_in <= 1'b0;
    host_u.send(mk(RCV_KIND_CHAN, 32'h0, 4'h0), res0);
    @(posedge mclk_in) ce_in <= 1'b1;
    chk({31'h0, res0.done}, 32'h0, "frozen while ce low");
    stat_chk();
    $display("test legacy done");
    for (int i = 0; i < 300; i++) begin
      if (i % 16 == 0) reg_wr(ADDR_MODE, (i % 32 == 0) ? 32'h3 : 32'($random(seed)) & 32'h0f);
      if (i % 16 == 5) reg_wr(ADDR_ESE, $random(seed));
      if (i % 16 == 9) reg_wr(ADDR_COND_EN, $random(seed));
      @(posedge mclk_in) cond_in <= 16'($random(seed));
      check_req(rnd_req());
      if (i % 6 == 0) pop_chk();
      if (i % 25 == 0) stat_chk();
      if (i % 50 == 49) reg_wr(ADDR_CMD, 32'h1 << CMD_CLS_BIT);
    end
    stat_chk();
    $display("test random done");
    test_done();
  end
endmodule : remote_cmd_validate_errq_test
